// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench;
	import tma_pkg::*;
	logic clk_in, rstn_in, ce_in, standby_in, ext_range_in, alert_mask_in, alert_is_overtemp_in, timeout_en_in;
	logic oneshot_in, bus_read_active_in, scl_pin_in, bus_release_out, busy_out, alert_out_n, overtemp_out_n;
	logic adc_clk_in, adc_done_in, adc_open_in, adc_start_out;
	logic [3:0] conv_rate_in;
	logic [2:0][7:0] high_limit_in, low_limit_in, overtemp_out_n_limit_in;
	logic [ST_W-1:0] status_clear_in, status_out;
	logic [7:0] rd_addr_in, rd_data_out;
	logic [9:0] adc_data_in;
	logic [1:0] adc_chan_out;
	logic [2:0][9:0] sensor_temp;
	logic [2:0] sensor_open;
	int miscompares, n_tests;
	tma_core #(.TIMEOUT_CYCLES(50), .TICK_CYCLES(4)) tma_core_inst (.clk_in(clk_in), .rstn_in(rstn_in),
		.ce_in(ce_in), .standby_in(standby_in), .ext_range_in(ext_range_in), .alert_mask_in(alert_mask_in),
		.alert_is_overtemp_in(alert_is_overtemp_in), .conv_rate_in(conv_rate_in), .timeout_en_in(timeout_en_in),
		.oneshot_in(oneshot_in), .high_limit_in(high_limit_in), .low_limit_in(low_limit_in),
		.overtemp_out_n_limit_in(overtemp_out_n_limit_in), .status_clear_in(status_clear_in), .bus_read_active_in(bus_read_active_in),
		.rd_addr_in(rd_addr_in), .scl_pin_in(scl_pin_in), .rd_data_out(rd_data_out), .status_out(status_out),
		.bus_release_out(bus_release_out), .busy_out(busy_out), .alert_out_n(alert_out_n),
		.overtemp_out_n(overtemp_out_n), .adc_clk_in(adc_clk_in), .adc_done_in(adc_done_in),
		.adc_data_in(adc_data_in), .adc_open_in(adc_open_in), .adc_start_out(adc_start_out),
		.adc_chan_out(adc_chan_out));
	tma_adc_model tma_adc_model_inst (.clk_in(adc_clk_in), .rstn_in(rstn_in), .start_in(adc_start_out),
		.chan_in(adc_chan_out), .temp_in(sensor_temp), .open_in(sensor_open), .done_out(adc_done_in),
		.data_out(adc_data_in), .open_out(adc_open_in));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// Odd offset keeps the link edges away from the system edges
	initial begin
		adc_clk_in = 1'b0;
		#3;
		forever #40 adc_clk_in = ~adc_clk_in;
	end
	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		if (miscompares == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic rounds(input int n);
		repeat (n) @(negedge busy_out);
		@(negedge clk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rd_addr_in = a;
		repeat (2) @(negedge clk_in);
		check({3'h0, rd_data_out}, {3'h0, e});
	endtask
	task automatic pulses(input int n, input int e);
		int c;
		c = 0;
		repeat (n) begin
			@(negedge clk_in);
			c += int'(bus_release_out);
		end
		check(11'(c), 11'(e));
	endtask
	task automatic t_values;
		rounds(3);
		rd(RA_LOCAL, 8'h19);
		rd(RA_REM1_HI, 8'h32);
		rd(RA_REM1_LO, 8'h40);
		rd(RA_REM2_HI, 8'h1E);
		rd(RA_REM2_LO, 8'h80);
		rd(8'h55, 8'h00);
		ext_range_in = 1'b1;
		rounds(2);
		rd(RA_REM1_HI, 8'h72);
		ext_range_in = 1'b0;
	endtask
	task automatic t_alarms;
		high_limit_in[1] = 8'h30;
		low_limit_in[0] = 8'h20;
		overtemp_out_n_limit_in[1] = 8'h31;
		sensor_open[2] = 1'b1;
		rounds(2);
		check(status_out, 11'h1 << (ST_HIGH + 1) | 11'h1 << ST_LOW | 11'h1 << (ST_OVERTEMP_OUT_N + 1) | 11'h1 << (ST_OPEN + 1));
		check({10'h0, alert_out_n}, 11'h0);
		check({10'h0, overtemp_out_n}, 11'h0);
		rd(RA_STAT_LO, 8'h8A);
		rd(RA_STAT_HI, 8'h04);
		alert_mask_in = 1'b1;
		rd(RA_LOCAL, 8'h19);
		check({10'h0, alert_out_n}, 11'h1);
		alert_is_overtemp_in = 1'b1;
		rd(RA_LOCAL, 8'h19);
		check({10'h0, alert_out_n}, 11'h0);
		high_limit_in = {3{8'h7F}};
		low_limit_in = '0;
		overtemp_out_n_limit_in = {3{8'h7F}};
		sensor_open = 3'h0;
		alert_mask_in = 1'b0;
		alert_is_overtemp_in = 1'b0;
		rounds(2);
		status_clear_in = '1;
		@(negedge clk_in);
		status_clear_in = '0;
		@(negedge clk_in);
		check(status_out, 11'h0);
		check({9'h0, alert_out_n, overtemp_out_n}, 11'h3);
	endtask
	task automatic t_modes;
		conv_rate_in = 4'h7;
		sensor_temp[0] = 10'h0A0;
		rounds(3);
		rd(RA_LOCAL, 8'h19);
		rounds(30);
		rd(RA_LOCAL, 8'h28);
		conv_rate_in = 4'h8;
		standby_in = 1'b1;
		@(negedge clk_in);
		while (busy_out !== 1'b0) @(negedge clk_in);
		sensor_temp[1] = 10'h0A0;
		repeat (300) @(negedge clk_in);
		check({10'h0, busy_out}, 11'h0);
		oneshot_in = 1'b1;
		@(negedge clk_in);
		oneshot_in = 1'b0;
		rounds(1);
		rd(RA_REM1_HI, 8'h28);
		standby_in = 1'b0;
		rounds(1);
		bus_read_active_in = 1'b1;
		sensor_temp[1] = 10'h0C9;
		repeat (600) @(negedge clk_in);
		check({3'h0, rd_data_out}, 11'h028);
		bus_read_active_in = 1'b0;
		rounds(2);
		rd(RA_REM1_HI, 8'h32);
	endtask
	task automatic t_timeout;
		scl_pin_in = 1'b0;
		pulses(120, 0);
		timeout_en_in = 1'b1;
		pulses(120, 1);
		scl_pin_in = 1'b1;
		pulses(4, 0);
		scl_pin_in = 1'b0;
		pulses(120, 1);
	endtask
	initial begin
		{rstn_in, standby_in, ext_range_in, alert_mask_in, alert_is_overtemp_in} = 5'h00;
		{timeout_en_in, oneshot_in, bus_read_active_in} = 3'h0;
		{ce_in, scl_pin_in} = 2'h3;
		conv_rate_in = 4'h8;
		high_limit_in = {3{8'h7F}};
		low_limit_in = '0;
		overtemp_out_n_limit_in = {3{8'h7F}};
		status_clear_in = '0;
		rd_addr_in = 8'h00;
		sensor_temp = {10'h07A, 10'h0C9, 10'h064};
		sensor_open = 3'h0;
		repeat (8) @(negedge clk_in);
		rstn_in = 1'b1;
		t_values();
		t_alarms();
		t_modes();
		t_timeout();
		report_and_stop();
	end
	initial begin
		#400_000;
		miscompares++;
		report_and_stop();
	end
endmodule // testbench

// >>> test/tma_adc_model.sv
`timescale 1ns/10ps
module tma_adc_model (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic [1:0] chan_in,
	input wire logic [2:0][9:0] temp_in,
	input wire logic [2:0] open_in,
	output logic done_out,
	output logic [9:0] data_out,
	output logic open_out
);
	logic [2:0] cnt_r;
	logic [1:0] ch_r;
	// A few link cycles of conversion time, so results never come back on the start edge
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_r <= 3'h0;
			ch_r <= 2'h0;
		end else if (start_in) begin
			cnt_r <= 3'h3;
			ch_r <= chan_in;
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end
	// Outside the done cycle the lines carry inverted data, not a stale copy
	always_comb begin
		done_out = (cnt_r == 3'h1);
		data_out = done_out ? temp_in[ch_r] : ~temp_in[ch_r];
		open_out = done_out ? open_in[ch_r] : ~open_in[ch_r];
	end
endmodule // tma_adc_model

// >>> test/tma_monitor.sv
`timescale 1ns/10ps
module tma_monitor #(
	parameter int TICK_CYCLES = tma_pkg::TICK_CYC
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic standby_in,
	input wire logic alert_mask_in,
	input wire logic alert_is_overtemp_in,
	input wire logic timeout_en_in,
	input wire logic oneshot_in,
	input wire logic [tma_pkg::ST_W-1:0] status_clear_in,
	input wire logic bus_read_active_in,
	input wire logic [7:0] rd_addr_in,
	input wire logic scl_pin_in,
	input wire logic [7:0] rd_data_out,
	input wire logic [tma_pkg::ST_W-1:0] status_out,
	input wire logic bus_release_out,
	input wire logic busy_out,
	input wire logic alert_out_n,
	input wire logic overtemp_out_n
);
	import tma_pkg::*;
	int idle_r;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Longest legal idle gap is the slowest rate's wait
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			idle_r <= 0;
		end else begin
			idle_r <= (busy_out || standby_in) ? 0 : idle_r + 1;
		end
	end
	a_free_run: assert property (idle_r <= 1024 * TICK_CYCLES + 8) else $error("converter stalled");
	a_stat_sticky: assert property (status_clear_in == '0 |=> (status_out & $past(status_out)) == $past(status_out))
		else $error("status flag lost");
	a_mask_alert: assert property ($past(alert_mask_in) && !$past(alert_is_overtemp_in) |-> alert_out_n)
		else $error("masked alarm low");
	a_pin_mirror: assert property ($past(alert_is_overtemp_in) |-> alert_out_n == overtemp_out_n)
		else $error("alarm pin not mirroring");
	a_standby_halt: assert property (standby_in && !oneshot_in && !$past(oneshot_in) && !busy_out |=> !busy_out)
		else $error("conversion in standby");
	a_no_release: assert property (!timeout_en_in && !$past(timeout_en_in) |-> !bus_release_out)
		else $error("release while disabled");
	a_release_pulse: assert property (bus_release_out |=> !bus_release_out) else $error("release too long");
	a_scl_rearm: assert property (scl_pin_in [*5] |=> !bus_release_out) else $error("release with clock high");
	a_read_hold: assert property ((bus_read_active_in && $stable(rd_addr_in) && status_clear_in == '0) [*3]
		|=> $stable(rd_data_out))
		else $error("result changed during read");
endmodule // tma_monitor
bind tma_core tma_monitor #(.TICK_CYCLES(TICK_CYCLES)) tma_monitor_inst (.clk_in(clk_in), .rstn_in(rstn_in),
	.standby_in(standby_in), .alert_mask_in(alert_mask_in), .alert_is_overtemp_in(alert_is_overtemp_in),
	.timeout_en_in(timeout_en_in), .oneshot_in(oneshot_in), .status_clear_in(status_clear_in),
	.bus_read_active_in(bus_read_active_in), .rd_addr_in(rd_addr_in), .scl_pin_in(scl_pin_in),
	.rd_data_out(rd_data_out), .status_out(status_out), .bus_release_out(bus_release_out), .busy_out(busy_out),
	.alert_out_n(alert_out_n), .overtemp_out_n(overtemp_out_n));

// >>> verilog/tma_core.sv
// What this block does
// - Converter runs freely until standby selected.
// - Cycle three channels, store each own register.
// - Compare limits; out-of-limit results set status flags.
// - Alarm low on high, low or open diode.
// - Overtemp output low above overtemperature limit.
// - Config makes alarm pin second overtemp output.
// - Host programs limits; device returns register contents.
// - Controls: standby, scale, alarm mask, pin, rate.
// - Low rates store average of sixteen cycles.
// - Rates 16, 32, 64 bypass averaging.
// - Optional bus timeout releases stalled transaction.
// - One-shot conversion starts right after stop.
// - No result writes during a bus read.
`timescale 1ns/10ps
module tma_core #(
	parameter int TIMEOUT_CYCLES = tma_pkg::TIMEOUT_CYC,
	parameter int TICK_CYCLES = tma_pkg::TICK_CYC
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic standby_in,
	input wire logic ext_range_in,
	input wire logic alert_mask_in,
	input wire logic alert_is_overtemp_in,
	input wire logic [3:0] conv_rate_in,
	input wire logic timeout_en_in,
	input wire logic oneshot_in,
	input wire logic [2:0][7:0] high_limit_in,
	input wire logic [2:0][7:0] low_limit_in,
	input wire logic [2:0][7:0] overtemp_out_n_limit_in,
	input wire logic [tma_pkg::ST_W-1:0] status_clear_in,
	input wire logic bus_read_active_in,
	input wire logic [7:0] rd_addr_in,
	input wire logic scl_pin_in,
	output logic [7:0] rd_data_out,
	output logic [tma_pkg::ST_W-1:0] status_out,
	output logic bus_release_out,
	output logic busy_out,
	output logic alert_out_n,
	output logic overtemp_out_n,
	input wire logic adc_clk_in,
	input wire logic adc_done_in,
	input wire logic [9:0] adc_data_in,
	input wire logic adc_open_in,
	output logic adc_start_out,
	output logic [1:0] adc_chan_out
);
	import tma_pkg::*;

	// Any channel above its overtemperature limit pulls the comparator pins
	function automatic logic any_over(input logic [ST_W-1:0] flags);
		return |flags[ST_OVERTEMP_OUT_N +: NUM_CH];
	endfunction

	typedef struct packed {
		tma_state_t st;
		logic [1:0] ch;
		logic oneshot_pend;
		logic oneshot_run;
		logic req_tgl;
		logic ack_s1;
		logic ack_s2;
		logic ack_seen;
		logic scl_s1;
		logic scl_s2;
		logic [23:0] tick_cnt;
		logic [10:0] gap_cnt;
		logic [23:0] to_cnt;
		logic to_fired;
		logic release_p;
		logic [3:0] avg_cnt;
		logic [2:0][13:0] acc;
		logic [2:0][9:0] temp;
		logic [ST_W-1:0] live;
		logic [ST_W-1:0] status;
		logic alert_n;
		logic overtemp_out_n_n;
		logic [7:0] rdata;
	} tma_sys_t;

	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_seen;
		logic busy;
		logic start;
		logic [1:0] ch;
		logic [9:0] data;
		logic open;
		logic ack_tgl;
	} tma_link_t;

	tma_sys_t r;
	tma_sys_t r_nxt;
	tma_link_t l_r;
	tma_link_t l_nxt;

	logic [3:0] rate_c;
	logic [10:0] gap_len;
	logic noavg;
	logic [13:0] sum;
	logic [9:0] val;
	logic wr;
	logic [ST_W-1:0] set_v;

	assign rate_c = (conv_rate_in > RATE_MAX) ? RATE_MAX : conv_rate_in;
	assign gap_len = GAP_FULL >> rate_c;
	// One-shot rounds always store single samples
	assign noavg = (rate_c >= RATE_NOAVG_MIN) || r.oneshot_run;

	// System domain: sequencer, averaging, limits, readback, timeout
	always_comb begin
		r_nxt = r;
		sum = 14'h0000;
		val = 10'h000;
		wr = 1'b0;
		set_v = '0;
		r_nxt.release_p = 1'b0;
		r_nxt.ack_s1 = l_r.ack_tgl;
		r_nxt.ack_s2 = r.ack_s1;
		r_nxt.scl_s1 = scl_pin_in;
		r_nxt.scl_s2 = r.scl_s1;
		// A pulse in normal mode is dropped so it cannot fire later in standby
		if (oneshot_in && standby_in) begin
			r_nxt.oneshot_pend = 1'b1;
		end
		case (r.st)
			S_IDLE: begin
				if (!standby_in || r.oneshot_pend) begin
					r_nxt.oneshot_run = standby_in && r.oneshot_pend;
					r_nxt.oneshot_pend = 1'b0;
					r_nxt.ch = CH_LOCAL;
					r_nxt.st = S_REQ;
				end
			end
			S_REQ: begin
				// Channel stays stable until the ack returns
				r_nxt.req_tgl = !r.req_tgl;
				r_nxt.st = S_WAIT;
			end
			S_WAIT: begin
				if (r.ack_s2 != r.ack_seen) begin
					r_nxt.ack_seen = r.ack_s2;
					r_nxt.st = S_STORE;
				end
			end
			S_STORE: begin
				if (!bus_read_active_in) begin
					sum = r.acc[r.ch] + {{4{l_r.data[9]}}, l_r.data};
					if (noavg) begin
						val = tma_fmt(l_r.data, ext_range_in);
						wr = 1'b1;
						r_nxt.acc[r.ch] = 14'h0000;
					end else if (r.avg_cnt == AVG_LAST) begin
						val = tma_fmt(sum[13:AVG_SHIFT], ext_range_in);
						wr = 1'b1;
						r_nxt.acc[r.ch] = 14'h0000;
					end else begin
						r_nxt.acc[r.ch] = sum;
					end
					if (wr) begin
						r_nxt.temp[r.ch] = val;
						r_nxt.live[ST_HIGH + r.ch] = val[9:2] > high_limit_in[r.ch];
						r_nxt.live[ST_LOW + r.ch] = val[9:2] < low_limit_in[r.ch];
						r_nxt.live[ST_OVERTEMP_OUT_N + r.ch] = val[9:2] > overtemp_out_n_limit_in[r.ch];
					end
					if (r.ch != CH_LOCAL) begin
						r_nxt.live[ST_OPEN + r.ch - 1] = l_r.open;
					end
					if (r.ch == CH_LAST) begin
						r_nxt.avg_cnt = noavg ? 4'h0 : r.avg_cnt + 4'h1;
						r_nxt.tick_cnt = 24'h000000;
						r_nxt.gap_cnt = 11'h000;
						r_nxt.st = S_GAP;
					end else begin
						r_nxt.ch = r.ch + 2'h1;
						r_nxt.st = S_REQ;
					end
				end
			end
			S_GAP: begin
				if (r.oneshot_run || standby_in) begin
					r_nxt.oneshot_run = 1'b0;
					r_nxt.st = S_IDLE;
				end else if (r.tick_cnt == 24'(TICK_CYCLES - 1)) begin
					r_nxt.tick_cnt = 24'h000000;
					r_nxt.gap_cnt = r.gap_cnt + 11'h001;
					if (r.gap_cnt + 11'h001 >= gap_len) begin
						r_nxt.st = S_IDLE;
					end
				end else begin
					r_nxt.tick_cnt = r.tick_cnt + 24'h000001;
				end
			end
			default: begin
				r_nxt.st = S_IDLE;
			end
		endcase
		// New flags win over a clear in the same cycle
		set_v = r_nxt.live & ~r.live | (r_nxt.live & {ST_W{wr || r.st == S_STORE}});
		r_nxt.status = (r.status & ~status_clear_in) | set_v;
		// Pins follow live comparisons so they stay fail-safe
		r_nxt.overtemp_out_n_n = !any_over(r.live);
		if (alert_is_overtemp_in) begin
			r_nxt.alert_n = !any_over(r.live);
		end else begin
			r_nxt.alert_n = alert_mask_in || !(|r.live[ST_HIGH +: 6] || |r.live[ST_OPEN +: 2]);
		end
		// Registered readback gives the host one settled byte per address
		case (rd_addr_in)
			RA_LOCAL: r_nxt.rdata = r.temp[0][9:2];
			RA_REM1_HI: r_nxt.rdata = r.temp[1][9:2];
			RA_REM1_LO: r_nxt.rdata = {r.temp[1][1:0], 6'h00};
			RA_REM2_HI: r_nxt.rdata = r.temp[2][9:2];
			RA_REM2_LO: r_nxt.rdata = {r.temp[2][1:0], 6'h00};
			RA_STAT_LO: r_nxt.rdata = r.status[7:0];
			RA_STAT_HI: r_nxt.rdata = {5'h00, r.status[ST_W-1:8]};
			default: r_nxt.rdata = 8'h00;
		endcase
		// Timeout only counts while enabled; fires once per low period
		// 24 bits hold the 25 ms default at 100 MHz
		if (!timeout_en_in || r.scl_s2) begin
			r_nxt.to_cnt = 24'h000000;
			r_nxt.to_fired = 1'b0;
		end else if (!r.to_fired) begin
			if (r.to_cnt == 24'(TIMEOUT_CYCLES - 1)) begin
				r_nxt.to_fired = 1'b1;
				r_nxt.release_p = 1'b1;
			end else begin
				r_nxt.to_cnt = r.to_cnt + 24'h000001;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			r <= '0;
			r.st <= S_IDLE;
			r.status <= STATUS_RST;
			r.alert_n <= 1'b1;
			r.overtemp_out_n_n <= 1'b1;
			r.scl_s1 <= 1'b1;
			r.scl_s2 <= 1'b1;
			r.rdata <= RDATA_RST;
		end else if (ce_in) begin
			r <= r_nxt;
		end
	end

	// Link domain: hands one channel request to the front end per toggle
	always_comb begin
		l_nxt = l_r;
		l_nxt.start = 1'b0;
		l_nxt.req_s1 = r.req_tgl;
		l_nxt.req_s2 = l_r.req_s1;
		if (!l_r.busy && (l_r.req_s2 != l_r.req_seen)) begin
			l_nxt.req_seen = l_r.req_s2;
			l_nxt.busy = 1'b1;
			l_nxt.start = 1'b1;
			l_nxt.ch = r.ch; // Held stable by the request handshake
		end else if (l_r.busy && adc_done_in) begin
			l_nxt.data = adc_data_in;
			l_nxt.open = adc_open_in;
			l_nxt.busy = 1'b0;
			l_nxt.ack_tgl = !l_r.ack_tgl;
		end
	end

	// Not gated by ce_in: doing so would need ce_in synchronised into this clock
	always_ff @(posedge adc_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	assign rd_data_out = r.rdata;
	assign status_out = r.status;
	assign bus_release_out = r.release_p;
	assign busy_out = (r.st != S_IDLE);
	assign alert_out_n = r.alert_n;
	assign overtemp_out_n = r.overtemp_out_n_n;
	assign adc_start_out = l_r.start;
	assign adc_chan_out = l_r.ch;
endmodule // tma_core

// >>> verilog/tma_pkg.sv
package tma_pkg;
	// System clock and derived timing
	localparam int CLK_HZ = 100_000_000;
	localparam int TIMEOUT_MS = 25;
	localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
	localparam int TICK_US = 15625;
	localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;

	// Channels
	localparam int NUM_CH = 3;
	localparam logic [1:0] CH_LOCAL = 2'h0;
	localparam logic [1:0] CH_LAST = 2'h2;

	// Conversion rate codes: code k gives 2^k/16 conversions per second
	localparam logic [3:0] RATE_MAX = 4'hA;
	localparam logic [3:0] RATE_NOAVG_MIN = 4'h8;
	localparam logic [10:0] GAP_FULL = 11'h400;

	// Averaging
	localparam logic [3:0] AVG_LAST = 4'hF;
	localparam int AVG_SHIFT = 4;

	// Status layout
	localparam int ST_W = 11;
	localparam int ST_HIGH = 0;
	localparam int ST_LOW = 3;
	localparam int ST_OVERTEMP_OUT_N = 6;
	localparam int ST_OPEN = 9;
	localparam logic [ST_W-1:0] STATUS_RST = 11'h000;

	// Readback addresses
	localparam logic [7:0] RA_LOCAL = 8'h00;
	localparam logic [7:0] RA_REM1_HI = 8'h01;
	localparam logic [7:0] RA_STAT_LO = 8'h02;
	localparam logic [7:0] RA_REM1_LO = 8'h10;
	localparam logic [7:0] RA_STAT_HI = 8'h23;
	localparam logic [7:0] RA_REM2_HI = 8'h30;
	localparam logic [7:0] RA_REM2_LO = 8'h33;
	localparam logic [7:0] RDATA_RST = 8'h00;

	typedef enum logic [2:0] {S_IDLE, S_REQ, S_WAIT, S_STORE, S_GAP} tma_state_t;

	// Raw sample is two's complement degrees with two fraction bits
	function automatic logic [9:0] tma_fmt(input logic [9:0] raw, input logic ext);
		logic signed [8:0] ip;
		ip = $signed({raw[9], raw[9:2]}) + (ext ? 9'sh040 : 9'sh000);
		if (ip < 0) begin
			return 10'h000;
		end
		return {ip[7:0], raw[1:0]};
	endfunction
endpackage
